// *** rtl/cctnv_top.sv ***
/*
  Capacitor code trim front end: volatile code, non-volatile nibble
  programming, load of the stored word and operating mode select.
  Assumes an AHB-Lite master on hclk and a single slave on the bus.
*/
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
// Function
// - volatile write applies code at once
// - nibble write of zero erases it
// - nibble 0 low, 1 middle, 2 top
// - volatile mode keeps volatile code output
// - nibble writes accepted in any order
// - load copies memory into control register
// - command nibble 9 selects non-volatile mode
// - erase is zero in low data bits
module cctnv_top #(
  parameter int unsigned PROG_CYCLES = cctnv_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Capacitor control
  output logic [cctnv_pkg::CODE_W-1:0] capacitor_code_dac,
  output logic storage_mode_select
);

  typedef struct packed {
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [cctnv_pkg::CODE_W-1:0] vol;
    logic [cctnv_pkg::CODE_W-1:0] nvc;
    logic mode;
    logic [cctnv_pkg::CODE_W-1:0] dac;
    logic [31:0] rdata;
    logic ready;
    logic req;
    logic [cctnv_pkg::NADDR_W-1:0] raddr;
    logic [cctnv_pkg::NIB_W-1:0] rdat;
  } cctnv_top_t;

  cctnv_top_t s_q;
  cctnv_top_t s_d;
  logic ap;
  logic [3:0] cmd;

  cctnv_if nv_bus();

  cctnv_nvmem #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nvmem (
    .hclk(hclk),
    .hresetn(hresetn),
    .nv(nv_bus.mem)
  );

  // ----------------------------------------------------------------
  // Bus decode and register behaviour
  // ----------------------------------------------------------------
  // Transfer size is not checked: only whole-word accesses are expected
  assign ap = hsel && hready && (htrans == cctnv_pkg::HTRANS_NONSEQ);
  assign cmd = hwdata[cctnv_pkg::CFG1_CMD_LSB +: 4];

  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.ready = 1'b1;
    s_d.ph_wr = ap && hwrite;
    s_d.ph_addr = haddr[7:0];
    if (s_q.ph_wr) begin
      case (s_q.ph_addr)
        cctnv_pkg::OFS_VOL: begin
          s_d.vol = hwdata[cctnv_pkg::CODE_W-1:0];
          s_d.mode = cctnv_pkg::MODE_VOL;
        end
        cctnv_pkg::OFS_NVCMD: begin
          if (cmd == cctnv_pkg::CMD_SET_NV) begin
            s_d.mode = cctnv_pkg::MODE_NV;
          end else if (!nv_bus.busy && !s_q.req) begin
            // low four bits carry the nibble, zero erases
            // A write landing during programming is dropped, not queued
            s_d.req = 1'b1;
            s_d.raddr = hwdata[cctnv_pkg::CFG1_ADDR_LSB +: cctnv_pkg::NADDR_W];
            s_d.rdat = hwdata[cctnv_pkg::CFG0_DATA_LSB +: cctnv_pkg::NIB_W];
          end
        end
        cctnv_pkg::OFS_CTRL: begin
          if (hwdata[cctnv_pkg::CTRL_LOAD_BIT]) begin
            s_d.nvc = nv_bus.word;
          end
        end
        default: s_d.ready = 1'b1;
      endcase
    end
    // volatile code stays on output until mode changes
    // mode bit picks one of two codes
    s_d.dac = (s_d.mode == cctnv_pkg::MODE_NV) ? s_d.nvc : s_d.vol;
    // Read data reflects a write finishing in this same cycle
    s_d.rdata = '0;
    if (ap && !hwrite) begin
      case (haddr[7:0])
        cctnv_pkg::OFS_VOL: s_d.rdata = 32'(s_d.vol);
        cctnv_pkg::OFS_NVCTRL: s_d.rdata = 32'(s_d.nvc);
        cctnv_pkg::OFS_STATUS: begin
          s_d.rdata[cctnv_pkg::ST_MODE_BIT] = s_d.mode;
          s_d.rdata[cctnv_pkg::ST_BUSY_BIT] = nv_bus.busy || s_d.req;
          s_d.rdata[cctnv_pkg::ST_LAST_LSB +: cctnv_pkg::NADDR_W] = nv_bus.last;
          s_d.rdata[cctnv_pkg::ST_WORD_LSB +: cctnv_pkg::CODE_W] = nv_bus.word;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{ph_wr: 1'b0, ph_addr: '0, vol: cctnv_pkg::RST_CODE,
               nvc: cctnv_pkg::RST_CODE, mode: cctnv_pkg::RST_MODE,
               dac: cctnv_pkg::RST_CODE, rdata: '0, ready: 1'b1, req: 1'b0,
               raddr: '0, rdat: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign nv_bus.req = s_q.req;
  assign nv_bus.addr = s_q.raddr;
  assign nv_bus.data = s_q.rdat;
  assign hreadyout = s_q.ready;
  assign hrdata = s_q.rdata;
  assign hresp = cctnv_pkg::HRESP_OKAY;
  assign capacitor_code_dac = s_q.dac;
  assign storage_mode_select = s_q.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_vol_apply: assert property (
    s_q.ph_wr && s_q.ph_addr == cctnv_pkg::OFS_VOL
    |=> capacitor_code_dac == $past(hwdata[cctnv_pkg::CODE_W-1:0]) && !storage_mode_select)
    else $error("volatile code not applied at once");

  a_vol_hold: assert property (
    !storage_mode_select && !$past(storage_mode_select) && $stable(s_q.vol)
    |-> $stable(capacitor_code_dac))
    else $error("output moved in volatile mode");

  a_code_select: assert property (
    ##1 capacitor_code_dac == (storage_mode_select ? s_q.nvc : s_q.vol))
    else $error("output code does not follow mode bit");

  a_set_nv: assert property (
    s_q.ph_wr && s_q.ph_addr == cctnv_pkg::OFS_NVCMD && cmd == cctnv_pkg::CMD_SET_NV
    |=> storage_mode_select && !s_q.req)
    else $error("set non-volatile mode not taken");

  a_load_copy: assert property (
    s_q.ph_wr && s_q.ph_addr == cctnv_pkg::OFS_CTRL && hwdata[cctnv_pkg::CTRL_LOAD_BIT]
    |=> s_q.nvc == $past(nv_bus.word))
    else $error("load did not copy stored word");

  a_nib_issue: assert property (
    s_q.ph_wr && s_q.ph_addr == cctnv_pkg::OFS_NVCMD && cmd != cctnv_pkg::CMD_SET_NV
    && !nv_bus.busy && !s_q.req
    |=> s_q.req && s_q.rdat == $past(hwdata[cctnv_pkg::NIB_W-1:0]))
    else $error("nibble write not issued");

  a_prog_start: assert property (
    s_q.req |=> nv_bus.busy [*2])
    else $error("programming did not start");

  a_bus_okay: assert property (
    hreadyout && hresp == cctnv_pkg::HRESP_OKAY)
    else $error("slave stalled or answered error");

  c_vol_write: cover property (s_q.ph_wr && s_q.ph_addr == cctnv_pkg::OFS_VOL);
  c_erase: cover property (s_q.req && s_q.rdat == cctnv_pkg::NIB_ERASED);
  c_load: cover property ($changed(s_q.nvc));
  c_to_nv: cover property ($rose(storage_mode_select));

endmodule : cctnv_top

// *** rtl/cctnv_pkg.sv ***
/*
  Shared constants, types and helpers for the capacitor code trim and
  non-volatile programming block.
  Assumes a single 200 MHz clock and an AHB-Lite register bus.
*/
package cctnv_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W = 9;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned NIB_CNT = 3;
  localparam int unsigned NADDR_W = 2;
  localparam int unsigned MEM_W = NIB_W * NIB_CNT;
  localparam int unsigned CNT_W = 21;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_VOL = 8'h00;
  localparam logic [7:0] OFS_NVCMD = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_NVCTRL = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG1_CMD_LSB = 12;
  localparam int unsigned CFG1_ADDR_LSB = 13;
  localparam int unsigned CFG0_DATA_LSB = 0;
  localparam int unsigned CTRL_LOAD_BIT = 0;
  localparam int unsigned ST_MODE_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_LAST_LSB = 2;
  localparam int unsigned ST_WORD_LSB = 16;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_SET_NV = 4'h9;
  localparam logic [3:0] NIB_ERASED = 4'h0;
  localparam logic MODE_VOL = 1'b0;
  localparam logic MODE_NV = 1'b1;
  localparam logic RST_MODE = MODE_NV;
  localparam logic [CODE_W-1:0] RST_CODE = 9'h000;
  localparam logic [MEM_W-1:0] RST_MEM = 12'h000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_PNV_US = 5000;
  localparam int unsigned PROG_CYCLES =
    (T_PNV_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS * 1000;

  typedef enum logic [0:0] {PS_IDLE, PS_PROG} cctnv_pstate_t;

  // Nibble 0 is least significant; only bit 0 of nibble 2 is used
  function automatic logic [CODE_W-1:0] cctnv_pack(input logic [MEM_W-1:0] nib);
    return {nib[2*NIB_W], nib[NIB_W +: NIB_W], nib[0 +: NIB_W]};
  endfunction : cctnv_pack

endpackage : cctnv_pkg

// *** rtl/cctnv_if.sv ***
/*
  Carrier between the register front end and the nibble memory.
  Assumes both ends run on the same clock.
*/
interface cctnv_if;
  logic req;
  logic [cctnv_pkg::NADDR_W-1:0] addr;
  logic [cctnv_pkg::NIB_W-1:0] data;
  logic busy;
  logic [cctnv_pkg::NADDR_W-1:0] last;
  logic [cctnv_pkg::CODE_W-1:0] word;

  modport ctl (output req, output addr, output data, input busy, input last, input word);
  modport mem (input req, input addr, input data, output busy, output last, output word);
endinterface : cctnv_if

// *** rtl/cctnv_nvmem.sv ***
/*
  Three-nibble non-volatile store with a program timer.
  Assumes requests arrive only while busy is low, as one-cycle pulses.
*/
module cctnv_nvmem #(
  parameter int unsigned PROG_CYCLES = cctnv_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command side
  cctnv_if.mem nv
);

  typedef struct packed {
    cctnv_pkg::cctnv_pstate_t st;
    logic [cctnv_pkg::CNT_W-1:0] cnt;
    logic [cctnv_pkg::NADDR_W-1:0] addr;
    logic [cctnv_pkg::NIB_W-1:0] data;
    logic [cctnv_pkg::NADDR_W-1:0] last;
    logic [cctnv_pkg::MEM_W-1:0] nib;
  } cctnv_mem_t;

  cctnv_mem_t s_q;
  cctnv_mem_t s_d;
  logic commit;

  // ----------------------------------------------------------------
  // Program sequencing
  // ----------------------------------------------------------------
  assign commit = (s_q.st == cctnv_pkg::PS_PROG) && (s_q.cnt == '0);

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      cctnv_pkg::PS_IDLE: begin
        if (nv.req) begin
          s_d.st = cctnv_pkg::PS_PROG;
          s_d.cnt = cctnv_pkg::CNT_W'(PROG_CYCLES - 1);
          s_d.addr = nv.addr;
          s_d.data = nv.data;
        end
      end
      cctnv_pkg::PS_PROG: begin
        if (commit) begin
          s_d.st = cctnv_pkg::PS_IDLE;
          // any nibble order
          // Address 3 has no nibble behind it and stores nothing
          if (32'(s_q.addr) < cctnv_pkg::NIB_CNT) begin
            s_d.nib[32'(s_q.addr) * cctnv_pkg::NIB_W +: cctnv_pkg::NIB_W] = s_q.data;
            s_d.last = s_q.addr;
          end
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: s_d.st = cctnv_pkg::PS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: cctnv_pkg::PS_IDLE, cnt: '0, addr: '0, data: '0, last: '0,
               nib: cctnv_pkg::RST_MEM};
    end else begin
      s_q <= s_d;
    end
  end

  assign nv.busy = (s_q.st == cctnv_pkg::PS_PROG);
  assign nv.last = s_q.last;
  assign nv.word = cctnv_pkg::cctnv_pack(s_q.nib);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_erase_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    commit && s_q.data == cctnv_pkg::NIB_ERASED && s_q.addr == 2'h0
    |=> nv.word[cctnv_pkg::NIB_W-1:0] == cctnv_pkg::NIB_ERASED)
    else $error("erase did not clear nibble 0");

  a_mid_nibble: assert property (@(posedge hclk) disable iff (!hresetn)
    commit && s_q.addr == 2'h1
    |=> nv.word[cctnv_pkg::NIB_W +: cctnv_pkg::NIB_W] == $past(s_q.data))
    else $error("nibble 1 not in middle of stored word");

endmodule : cctnv_nvmem

// *** testbench/cctnv_ahb_master.sv ***
/*
  Bus master model acting as the trimming controller.
  Assumes one slave on hclk whose hreadyout is fed back as hready.
*/
module cctnv_ahb_master (
  // Clock
  input wire logic hclk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Single word transfer
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= cctnv_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    hsel <= 1'b0;
    // Released data must not keep looking valid
    hwdata <= ~d;
  endtask : xfer

  // ----------------------------------------------------------------
  // Trimming commands
  // ----------------------------------------------------------------
  // one nibble per write
  task automatic nibble(input logic [1:0] a, input logic [7:0] cfg0);
    logic [31:0] q;
    xfer(1'b1, cctnv_pkg::OFS_NVCMD, {16'h0000, 1'b0, a, 5'h00, cfg0}, q);
    // Busy shows two cycles after the write is taken
    repeat (2) @(posedge hclk);
    q = 32'h00000002;
    while (q[cctnv_pkg::ST_BUSY_BIT] !== 1'b0) begin
      xfer(1'b0, cctnv_pkg::OFS_STATUS, 32'h00000000, q);
    end
  endtask : nibble

  task automatic prog(input logic [8:0] code);
    nibble(2'h0, 8'hF0);
    nibble(2'h0, {4'h0, code[3:0]});
    nibble(2'h1, 8'hF0);
    nibble(2'h1, {4'h0, code[7:4]});
    nibble(2'h2, 8'hF0);
    nibble(2'h2, {7'h00, code[8]});
  endtask : prog

  task automatic load();
    logic [31:0] q;
    xfer(1'b1, cctnv_pkg::OFS_CTRL, 32'h00000001, q);
  endtask : load

  task automatic set_nv();
    logic [31:0] q;
    xfer(1'b1, cctnv_pkg::OFS_NVCMD, 32'h00009FFF, q);
  endtask : set_nv
endmodule : cctnv_ahb_master

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the capacitor code trim block.
  Assumes the master model is the only bus master.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, storage_mode_select;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] capacitor_code_dac;
  logic [8:0] vcodes [4] = '{9'h125, 9'h126, 9'h127, 9'h128};
  int bad_count = 0;
  int num_checks = 0;

  always #2.5 hclk = ~hclk;

  // Short program time keeps the run small
  cctnv_top #(.PROG_CYCLES(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .capacitor_code_dac(capacitor_code_dac), .storage_mode_select(storage_mode_select));

  cctnv_ahb_master m_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    m_u.xfer(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask : rd

  task automatic outs(input logic [8:0] code, input logic mode);
    @(negedge hclk);
    check({23'h000000, capacitor_code_dac}, {23'h000000, code});
    check({31'h00000000, storage_mode_select}, {31'h00000000, mode});
    check({30'h00000000, hresp, hreadyout}, 32'h00000001);
  endtask : outs

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    outs(9'h000, 1'b1);
    rd(cctnv_pkg::OFS_VOL, 32'h00000000);
    rd(cctnv_pkg::OFS_STATUS, 32'h00000001);
  endtask : t_reset

  task automatic t_volatile();
    foreach (vcodes[i]) begin
      m_u.xfer(1'b1, cctnv_pkg::OFS_VOL, {23'h000000, vcodes[i]}, q);
      outs(vcodes[i], 1'b0);
    end
    m_u.xfer(1'b1, 8'h20, 32'h000001FF, q);
    m_u.xfer(1'b1, cctnv_pkg::OFS_STATUS, 32'hFFFFFFFF, q);
    rd(8'h20, 32'h00000000);
    rd(cctnv_pkg::OFS_STATUS, 32'h00000000);
    rd(cctnv_pkg::OFS_VOL, 32'h00000128);
  endtask : t_volatile

  task automatic t_program();
    m_u.prog(9'h127);
    outs(9'h128, 1'b0);
    rd(cctnv_pkg::OFS_STATUS, 32'h01270008);
    rd(cctnv_pkg::OFS_NVCTRL, 32'h00000000);
    m_u.load();
    rd(cctnv_pkg::OFS_NVCTRL, 32'h00000127);
    outs(9'h128, 1'b0);
    m_u.set_nv();
    outs(9'h127, 1'b1);
    rd(cctnv_pkg::OFS_VOL, 32'h00000128);
  endtask : t_program

  task automatic t_order();
    for (int i = 2; i >= 0; i--) begin
      m_u.nibble(i[1:0], 8'h00);
    end
    m_u.nibble(2'h2, 8'h01);
    m_u.nibble(2'h1, 8'h0A);
    m_u.nibble(2'h0, 8'h05);
    rd(cctnv_pkg::OFS_STATUS, 32'h01A50001);
    outs(9'h127, 1'b1);
    m_u.load();
    outs(9'h1A5, 1'b1);
    m_u.nibble(2'h1, 8'h30);
    m_u.load();
    outs(9'h105, 1'b1);
    rd(cctnv_pkg::OFS_NVCTRL, 32'h00000105);
  endtask : t_order

  // Address 3 stores nothing, a write during programming is dropped,
  // a control write without the load bit leaves the register alone
  task automatic t_refuse();
    m_u.nibble(2'h3, 8'h0F);
    rd(cctnv_pkg::OFS_STATUS, 32'h01050005);
    m_u.xfer(1'b1, cctnv_pkg::OFS_NVCMD, 32'h00000000, q);
    m_u.nibble(2'h2, 8'h00);
    rd(cctnv_pkg::OFS_STATUS, 32'h01000001);
    m_u.xfer(1'b1, cctnv_pkg::OFS_CTRL, 32'hFFFFFFFE, q);
    outs(9'h105, 1'b1);
    rd(cctnv_pkg::OFS_NVCMD, 32'h00000000);
    rd(cctnv_pkg::OFS_CTRL, 32'h00000000);
    m_u.load();
    outs(9'h100, 1'b1);
  endtask : t_refuse

  // Reset in mid-run brings back the power-up state
  task automatic t_rerun();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    outs(9'h000, 1'b1);
    rd(cctnv_pkg::OFS_STATUS, 32'h00000001);
    rd(cctnv_pkg::OFS_VOL, 32'h00000000);
  endtask : t_rerun

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_volatile();
    t_program();
    t_order();
    t_refuse();
    t_rerun();
    print_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    print_verdict();
  end
endmodule : tb_top
